// ==== verilog/srtc_device.sv ====
// Behaviour
// - transfer starts on enable, command byte first
// - input bits sampled on shift clock rise
// - command bit 7 zero abandons transfer
// - bit 6 picks clock or RAM
// - bits 5:1 address, bit 0 direction
// - all bytes travel least significant first
// - output bits change on falling edges
// - enable low ends transfer, releases data
// - single write takes one byte, ignores rest
// - date rolls per month length and leap
// - host avoids writing fifty-nine seconds
// - first read bit on next falling edge
// - reads continue while enable stays high
// - address all ones selects burst mode
// - no storage at unused addresses
// - clock burst commits after eight bytes
// - RAM burst commits every byte at once
// - eight BCD timekeeping registers
// - seconds bit 7 halts the clock
// - hours bit 7 twelve-hour, bit 5 PM
// - control bit 7 blocks other writes
// - bursts start at address zero
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`include "srtc_defs.svh"
module srtc_device #(
	parameter int XTAL_DIV = `SRTC_XTAL_HZ
) (
	// system
	input  logic      clk,
	input  logic      rst,
	// crystal
	input  logic      crystal_in,
	output logic      crystal_out,
	// serial link
	srtc_if.device    link
);
	localparam int PW = $clog2(XTAL_DIV);

	logic [3:0]                   pin_s;
	logic                         sclk_q_r;
	logic                         xtal_q_r;
	logic                         rise;
	logic                         fall;
	logic                         xtal_rise;
	logic [7:0]                   sh_in;
	srtc_pkg::srtc_dev_state_type state_r;
	logic [2:0]                   bit_r;
	logic [7:0]                   sh_r;
	logic [7:0]                   hold_r;
	logic                         ram_sp_r;
	logic                         burst_r;
	logic [4:0]                   addr_r;
	logic [4:0]                   last;
	logic                         dout_r;
	logic                         oe_n_r;
	logic [7:0]                   stage_r [`SRTC_CLK_REGS];
	logic                         wr_pulse_r;
	logic                         wr_ram_r;
	logic [4:0]                   wr_addr_r;
	logic [7:0]                   wr_data_r;
	logic                         commit_r;
	logic [7:0]                   tk_r [`SRTC_CLK_REGS];
	logic [7:0]                   tk_nxt [`SRTC_CLK_REGS];
	logic [7:0]                   ram_r [`SRTC_RAM_BYTES];
	logic [7:0]                   rd_val;
	logic                         wp;
	logic                         halt;
	logic [PW-1:0]                pre_r;
	logic                         tick_r;

	srtc_sync #(.WIDTH(4)) u_sync (
		.clk     (clk),
		.rst     (rst),
		.async_i ({crystal_in, link.io, link.ce, link.sclk}),
		.level_o (pin_s)
	);

	assign rise      = pin_s[0] & !sclk_q_r;
	assign fall      = !pin_s[0] & sclk_q_r;
	assign xtal_rise = pin_s[3] & !xtal_q_r;
	assign sh_in     = {pin_s[2], sh_r[7:1]};
	assign wp        = tk_r[`SRTC_R_CTRL][`SRTC_WP_BIT];
	assign halt      = tk_r[`SRTC_R_SEC][`SRTC_HALT_BIT];
	assign last      = ram_sp_r ? `SRTC_RAM_LAST : `SRTC_CLK_LAST;
	assign link.dev_io_o    = dout_r;
	assign link.dev_io_oe_n = oe_n_r;

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			sclk_q_r    <= 1'b0;
			xtal_q_r    <= 1'b0;
			crystal_out <= 1'b0;
		end
		else
		begin
			sclk_q_r    <= pin_s[0];
			xtal_q_r    <= pin_s[3];
			// a halted oscillator stops swinging its output
			crystal_out <= !halt & !pin_s[3];
		end

	// unmapped addresses read as zero
	always_comb
	begin
		rd_val = 8'h00;
		if (ram_sp_r)
		begin
			if (addr_r <= `SRTC_RAM_LAST)
				rd_val = ram_r[addr_r];
		end
		else if (addr_r <= `SRTC_CLK_LAST)
			rd_val = tk_r[addr_r[2:0]];
	end

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			state_r    <= srtc_pkg::DS_IDLE;
			bit_r      <= 3'h0;
			sh_r       <= 8'h00;
			hold_r     <= 8'h00;
			ram_sp_r   <= 1'b0;
			burst_r    <= 1'b0;
			addr_r     <= 5'h00;
			dout_r     <= 1'b0;
			oe_n_r     <= 1'b1;
			wr_pulse_r <= 1'b0;
			wr_ram_r   <= 1'b0;
			wr_addr_r  <= 5'h00;
			wr_data_r  <= 8'h00;
			commit_r   <= 1'b0;
			for (int i = 0; i < `SRTC_CLK_REGS; i++)
				stage_r[i] <= 8'h00;
		end
		else
		begin
			wr_pulse_r <= 1'b0;
			commit_r   <= 1'b0;
			if (!pin_s[1])
			begin
				state_r <= srtc_pkg::DS_IDLE;
				oe_n_r  <= 1'b1;
			end
			else
				case (state_r)
					srtc_pkg::DS_IDLE:
					begin
						state_r <= srtc_pkg::DS_CMD;
						bit_r   <= 3'h0;
					end
					srtc_pkg::DS_CMD:
						if (rise)
						begin
							sh_r  <= sh_in;
							bit_r <= bit_r + 3'h1;
							if (bit_r == 3'h7)
							begin
								bit_r    <= 3'h0;
								ram_sp_r <= sh_in[`SRTC_CMD_RAM_BIT];
								burst_r  <= sh_in[5:1] == `SRTC_ADDR_BURST;
								// bursts always begin at the bottom
								addr_r   <= (sh_in[5:1] == `SRTC_ADDR_BURST) ? 5'h00 : sh_in[5:1];
								if (!sh_in[`SRTC_CMD_START_BIT])
									state_r <= srtc_pkg::DS_IGN;
								else if (sh_in[`SRTC_CMD_RD_BIT])
									state_r <= srtc_pkg::DS_RD;
								else
									state_r <= srtc_pkg::DS_WR;
							end
						end
					srtc_pkg::DS_WR:
						if (rise)
						begin
							sh_r  <= sh_in;
							bit_r <= bit_r + 3'h1;
							if (bit_r == 3'h7)
							begin
								addr_r <= addr_r + 5'h01;
								if (!burst_r || ram_sp_r)
								begin
									wr_pulse_r <= 1'b1;
									wr_ram_r   <= ram_sp_r;
									wr_addr_r  <= addr_r;
									wr_data_r  <= sh_in;
								end
								else
									stage_r[addr_r[2:0]] <= sh_in;
								if (!burst_r)
									state_r <= srtc_pkg::DS_IGN;
								else if (addr_r == last)
								begin
									commit_r <= !ram_sp_r;
									state_r  <= srtc_pkg::DS_IGN;
								end
							end
						end
					srtc_pkg::DS_RD:
						if (fall)
						begin
							oe_n_r <= 1'b0;
							bit_r  <= bit_r + 3'h1;
							// the byte is frozen at its first bit so a tick cannot tear it
							if (bit_r == 3'h0)
							begin
								dout_r <= rd_val[0];
								hold_r <= rd_val;
							end
							else
								dout_r <= hold_r[bit_r];
							if (bit_r == 3'h7 && burst_r)
								addr_r <= (addr_r == last) ? 5'h00 : addr_r + 5'h01;
						end
					srtc_pkg::DS_IGN:
						state_r <= srtc_pkg::DS_IGN;
					default:
						state_r <= srtc_pkg::DS_IDLE;
				endcase
		end

	// one-second prescaler, frozen and cleared while halted
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			pre_r  <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			tick_r <= 1'b0;
			if (halt)
				pre_r <= '0;
			else if (xtal_rise)
			begin
				if (pre_r == PW'(XTAL_DIV - 1))
				begin
					pre_r  <= '0;
					tick_r <= 1'b1;
				end
				else
					pre_r <= pre_r + PW'(1);
			end
		end

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	function automatic logic [7:0] month_len(input logic [7:0] mon, input logic leap);
		case (mon)
			8'h02:                      month_len = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
			default:                    month_len = 8'h31;
		endcase
	endfunction

	logic       cy;
	logic       cd;
	logic [7:0] h_inc;
	logic [4:0] ysum;

	always_comb
	begin
		tk_nxt = tk_r;
		cy     = 1'b0;
		cd     = 1'b0;
		h_inc  = bcd_inc({3'h0, tk_r[`SRTC_R_HR][4:0]});
		// ten years is two modulo four, so the tens digit counts twice
		ysum   = {tk_r[`SRTC_R_YEAR][7:4], 1'b0} + {1'b0, tk_r[`SRTC_R_YEAR][3:0]};
		if (tk_r[`SRTC_R_SEC][6:0] == 7'h59)
		begin
			tk_nxt[`SRTC_R_SEC] = 8'h00;
			if (tk_r[`SRTC_R_MIN] == 8'h59)
			begin
				tk_nxt[`SRTC_R_MIN] = 8'h00;
				cy = 1'b1;
			end
			else
				tk_nxt[`SRTC_R_MIN] = bcd_inc(tk_r[`SRTC_R_MIN]);
		end
		else
			tk_nxt[`SRTC_R_SEC] = bcd_inc(tk_r[`SRTC_R_SEC]);
		if (cy)
		begin
			if (tk_r[`SRTC_R_HR][`SRTC_H12_BIT])
			begin
				if (tk_r[`SRTC_R_HR][4:0] == 5'h11)
				begin
					tk_nxt[`SRTC_R_HR] = {2'b10, !tk_r[`SRTC_R_HR][`SRTC_PM_BIT], 5'h12};
					cd = tk_r[`SRTC_R_HR][`SRTC_PM_BIT];
				end
				else if (tk_r[`SRTC_R_HR][4:0] == 5'h12)
					tk_nxt[`SRTC_R_HR] = {tk_r[`SRTC_R_HR][7:5], 5'h01};
				else
					tk_nxt[`SRTC_R_HR] = {tk_r[`SRTC_R_HR][7:5], h_inc[4:0]};
			end
			else if (tk_r[`SRTC_R_HR][5:0] == 6'h23)
			begin
				tk_nxt[`SRTC_R_HR] = 8'h00;
				cd = 1'b1;
			end
			else
				tk_nxt[`SRTC_R_HR] = bcd_inc(tk_r[`SRTC_R_HR]);
		end
		if (cd)
		begin
			tk_nxt[`SRTC_R_DAY] = (tk_r[`SRTC_R_DAY] >= 8'h07) ? 8'h01 : tk_r[`SRTC_R_DAY] + 8'h01;
			if (tk_r[`SRTC_R_DATE] >= month_len(tk_r[`SRTC_R_MON], ysum[1:0] == 2'b00))
			begin
				tk_nxt[`SRTC_R_DATE] = 8'h01;
				if (tk_r[`SRTC_R_MON] >= 8'h12)
				begin
					tk_nxt[`SRTC_R_MON]  = 8'h01;
					tk_nxt[`SRTC_R_YEAR] = (tk_r[`SRTC_R_YEAR] == 8'h99) ? 8'h00
						: bcd_inc(tk_r[`SRTC_R_YEAR]);
				end
				else
					tk_nxt[`SRTC_R_MON] = bcd_inc(tk_r[`SRTC_R_MON]);
			end
			else
				tk_nxt[`SRTC_R_DATE] = bcd_inc(tk_r[`SRTC_R_DATE]);
		end
	end

	// a clock-register write or burst commit in the tick's cycle wins; the tick is lost, which is why
	// writing a final second of a minute is best avoided
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			tk_r[`SRTC_R_SEC]  <= `SRTC_RST_SEC;
			tk_r[`SRTC_R_MIN]  <= `SRTC_RST_MIN;
			tk_r[`SRTC_R_HR]   <= `SRTC_RST_HR;
			tk_r[`SRTC_R_DATE] <= `SRTC_RST_DATE;
			tk_r[`SRTC_R_MON]  <= `SRTC_RST_MON;
			tk_r[`SRTC_R_DAY]  <= `SRTC_RST_DAY;
			tk_r[`SRTC_R_YEAR] <= `SRTC_RST_YEAR;
			tk_r[`SRTC_R_CTRL] <= `SRTC_RST_CTRL;
		end
		else if (wr_pulse_r && !wr_ram_r)
		begin
			if (wr_addr_r == {2'b00, `SRTC_R_CTRL})
				tk_r[`SRTC_R_CTRL] <= wr_data_r & `SRTC_CTRL_MASK;
			else if (!wp && wr_addr_r <= `SRTC_CLK_LAST)
				tk_r[wr_addr_r[2:0]] <= wr_data_r;
		end
		else if (commit_r)
		begin
			for (int i = 0; i < `SRTC_CLK_REGS - 1; i++)
				if (!wp)
					tk_r[i] <= stage_r[i];
			tk_r[`SRTC_R_CTRL] <= stage_r[`SRTC_R_CTRL] & `SRTC_CTRL_MASK;
		end
		else if (tick_r)
			tk_r <= tk_nxt;

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			for (int i = 0; i < `SRTC_RAM_BYTES; i++)
				ram_r[i] <= 8'h00;
		end
		else if (wr_pulse_r && wr_ram_r && !wp && wr_addr_r <= `SRTC_RAM_LAST)
			ram_r[wr_addr_r] <= wr_data_r;
endmodule // srtc_device

// ==== common/srtc_defs.svh ====
`ifndef SRTC_DEFS_SVH
`define SRTC_DEFS_SVH

// command byte fields
`define SRTC_CMD_START_BIT 7
`define SRTC_CMD_RAM_BIT   6
`define SRTC_CMD_RD_BIT    0
`define SRTC_ADDR_BURST    5'h1f

// storage sizes and last burst addresses
`define SRTC_CLK_REGS      8
`define SRTC_RAM_BYTES     24
`define SRTC_CLK_LAST      5'h07
`define SRTC_RAM_LAST      5'h17

// timekeeping register indices
`define SRTC_R_SEC         3'h0
`define SRTC_R_MIN         3'h1
`define SRTC_R_HR          3'h2
`define SRTC_R_DATE        3'h3
`define SRTC_R_MON         3'h4
`define SRTC_R_DAY         3'h5
`define SRTC_R_YEAR        3'h6
`define SRTC_R_CTRL        3'h7

// field positions
`define SRTC_HALT_BIT      7
`define SRTC_H12_BIT       7
`define SRTC_PM_BIT        5
`define SRTC_WP_BIT        7
`define SRTC_CTRL_MASK     8'h80

// reset values
`define SRTC_RST_SEC       8'h00
`define SRTC_RST_MIN       8'h00
`define SRTC_RST_HR        8'h00
`define SRTC_RST_DATE      8'h01
`define SRTC_RST_MON       8'h01
`define SRTC_RST_DAY       8'h01
`define SRTC_RST_YEAR      8'h00
`define SRTC_RST_CTRL      8'h00

// timing
`define SRTC_XTAL_HZ       32768
`define SRTC_CLK_NS        50
`define SRTC_SCLK_HALF_NS  600
`define SRTC_SCLK_HALF_CYC ((`SRTC_SCLK_HALF_NS + `SRTC_CLK_NS - 1) / `SRTC_CLK_NS)

// host wishbone map
`define SRTC_WB_CTRL       8'h00
`define SRTC_WB_STATUS     8'h04
`define SRTC_CTRL_GO_BIT   0
`define SRTC_CTRL_STOP_BIT 1

`endif

// ==== common/srtc_pkg.sv ====
package srtc_pkg;

	typedef enum logic [2:0] {
		DS_IDLE,
		DS_CMD,
		DS_WR,
		DS_RD,
		DS_IGN
	} srtc_dev_state_type;

	typedef enum logic [1:0] {
		HS_IDLE,
		HS_SETUP,
		HS_LOW,
		HS_HIGH
	} srtc_host_state_type;

endpackage

// ==== common/srtc_if.sv ====
interface srtc_if;
	logic ce;
	logic sclk;
	logic host_io_o;
	logic host_io_oe_n;
	logic dev_io_o;
	logic dev_io_oe_n;
	logic io;

	// resolved data wire, pulled high when nobody drives
	assign io = !host_io_oe_n ? host_io_o : (!dev_io_oe_n ? dev_io_o : 1'b1);

	modport device (input ce, input sclk, input io, output dev_io_o, output dev_io_oe_n);
	modport host (output ce, output sclk, output host_io_o, output host_io_oe_n, input io);
endinterface

// ==== verilog/srtc_sync.sv ====
module srtc_sync #(
	parameter int WIDTH = 1
) (
	// system
	input  logic             clk,
	input  logic             rst,
	// pins
	input  logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			s1_r    <= '0;
			s2_r    <= '0;
			s3_r    <= '0;
			level_o <= '0;
		end
		else
		begin
			s1_r    <= async_i;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			// a bit changes only once the last two stages agree
			level_o <= (s2_r & s3_r) | (level_o & (s2_r ^ s3_r));
		end
endmodule // srtc_sync

// ==== verilog/srtc_host.sv ====
`include "srtc_defs.svh"
module srtc_host #(
	parameter int HALF_CYC = `SRTC_SCLK_HALF_CYC
) (
	// system
	input  logic        clk,
	input  logic        rst,
	// wishbone slave
	input  logic        wb_cyc_i,
	input  logic        wb_stb_i,
	input  logic        wb_we_i,
	input  logic [7:0]  wb_adr_i,
	input  logic [31:0] wb_dat_i,
	input  logic [3:0]  wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic        wb_ack_o,
	// serial link
	srtc_if.host        link
);
	srtc_pkg::srtc_host_state_type state_r;
	logic [7:0]                    cnt_r;
	logic [2:0]                    bit_r;
	logic [7:0]                    tx_r;
	logic [7:0]                    rx_r;
	logic                          first_r;
	logic                          rd_mode_r;
	logic                          ce_r;
	logic                          sclk_r;
	logic                          hout_r;
	logic                          hoe_n_r;
	logic                          io_s;
	logic                          busy;
	logic                          act;
	logic                          ctrl_wr;
	logic                          half_done;

	srtc_sync #(.WIDTH(1)) u_sync (
		.clk     (clk),
		.rst     (rst),
		.async_i (link.io),
		.level_o (io_s)
	);

	assign busy      = state_r != srtc_pkg::HS_IDLE;
	assign act       = wb_cyc_i & wb_stb_i & !wb_ack_o;
	// acts at the edge where the master samples ack, never while the request is unanswered
	assign ctrl_wr   = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0]
		& (wb_adr_i == `SRTC_WB_CTRL) & !busy;
	assign half_done = cnt_r == 8'(HALF_CYC - 1);
	assign link.ce           = ce_r;
	assign link.sclk         = sclk_r;
	assign link.host_io_o    = hout_r;
	assign link.host_io_oe_n = hoe_n_r;

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= act;
			if (act && !wb_we_i)
				wb_dat_o <= (wb_adr_i == `SRTC_WB_STATUS) ? {16'h0000, rx_r, 6'h00, ce_r, busy}
					: 32'h0000_0000;
		end

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			state_r   <= srtc_pkg::HS_IDLE;
			cnt_r     <= 8'h00;
			bit_r     <= 3'h0;
			tx_r      <= 8'h00;
			rx_r      <= 8'h00;
			first_r   <= 1'b0;
			rd_mode_r <= 1'b0;
			ce_r      <= 1'b0;
			sclk_r    <= 1'b0;
			hout_r    <= 1'b0;
			hoe_n_r   <= 1'b1;
		end
		else
			case (state_r)
				srtc_pkg::HS_IDLE:
				begin
					cnt_r <= 8'h00;
					bit_r <= 3'h0;
					if (ctrl_wr && wb_dat_i[`SRTC_CTRL_GO_BIT])
					begin
						tx_r <= wb_dat_i[15:8];
						if (!ce_r)
						begin
							ce_r      <= 1'b1;
							first_r   <= 1'b1;
							rd_mode_r <= 1'b0;
							state_r   <= srtc_pkg::HS_SETUP;
						end
						else
							state_r <= srtc_pkg::HS_LOW;
					end
					else if (ctrl_wr && wb_dat_i[`SRTC_CTRL_STOP_BIT])
					begin
						ce_r    <= 1'b0;
						hoe_n_r <= 1'b1;
					end
				end
				srtc_pkg::HS_SETUP:
				begin
					cnt_r <= cnt_r + 8'h01;
					if (half_done)
					begin
						cnt_r   <= 8'h00;
						state_r <= srtc_pkg::HS_LOW;
					end
				end
				srtc_pkg::HS_LOW:
				begin
					cnt_r <= cnt_r + 8'h01;
					if (cnt_r == 8'h00)
					begin
						hout_r  <= tx_r[bit_r];
						hoe_n_r <= rd_mode_r & !first_r;
					end
					// sample late in the low phase, after the device's output has settled
					if (half_done)
					begin
						rx_r    <= {io_s, rx_r[7:1]};
						sclk_r  <= 1'b1;
						cnt_r   <= 8'h00;
						state_r <= srtc_pkg::HS_HIGH;
					end
				end
				srtc_pkg::HS_HIGH:
				begin
					cnt_r <= cnt_r + 8'h01;
					if (half_done)
					begin
						sclk_r <= 1'b0;
						cnt_r  <= 8'h00;
						bit_r  <= bit_r + 3'h1;
						state_r <= srtc_pkg::HS_LOW;
						if (bit_r == 3'h7)
						begin
							hoe_n_r <= 1'b1;
							state_r <= srtc_pkg::HS_IDLE;
							if (first_r)
							begin
								first_r   <= 1'b0;
								rd_mode_r <= tx_r[`SRTC_CMD_RD_BIT];
							end
						end
					end
				end
				default:
					state_r <= srtc_pkg::HS_IDLE;
			endcase
endmodule // srtc_host

// ==== verif/srtc_link_sva.sv ====
module srtc_link_sva (
	// system
	input wire logic clk,
	input wire logic rst,
	// link
	input wire logic ce,
	input wire logic sclk,
	input wire logic host_io_o,
	input wire logic host_io_oe_n,
	input wire logic dev_io_o,
	input wire logic dev_io_oe_n,
	input wire logic io
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic       sclk_d_r;
	logic [3:0] cnt_r;
	logic [7:0] cmd_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sclk_d_r <= 1'b0;
		else
			sclk_d_r <= sclk;
	end

	// counts shift clock rises of the frame, stops once the command is in
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_r <= 4'h0;
		else if (!ce)
			cnt_r <= 4'h0;
		else if (sclk && !sclk_d_r && cnt_r != 4'h8)
			cnt_r <= cnt_r + 4'h1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cmd_r <= 8'h00;
		else if (ce && sclk && !sclk_d_r && cnt_r != 4'h8)
			cmd_r <= {io, cmd_r[7:1]};
	end

	sequence s_ce_up;
		$rose(ce);
	endsequence
	sequence s_sclk_rest;
		!sclk [*6];
	endsequence

	property p_ce_setup;
		s_ce_up |-> s_sclk_rest;
	endproperty
	property p_idle;
		!ce |-> !sclk;
	endproperty
	property p_release;
		$fell(ce) |-> ##[1:8] dev_io_oe_n;
	endproperty
	property p_out_fall;
		!dev_io_oe_n && $changed(dev_io_o) |-> !sclk;
	endproperty
	property p_no_clash;
		!(!host_io_oe_n && !dev_io_oe_n);
	endproperty
	property p_drive_start;
		$fell(dev_io_oe_n) |-> !sclk && ce && cnt_r == 4'h8;
	endproperty
	property p_host_setup;
		$rose(sclk) && !host_io_oe_n |-> $stable(host_io_o) ##1 $stable(host_io_o);
	endproperty
	property p_cmd_quiet;
		ce && cnt_r == 4'h8 && !(cmd_r[7] && cmd_r[0]) |-> dev_io_oe_n;
	endproperty
	property p_silent;
		ce && cnt_r inside {[4'h1:4'h7]} |-> dev_io_oe_n;
	endproperty

	a_ce_setup: assert property (p_ce_setup) else $error("shift clock too soon after enable");
	a_idle: assert property (p_idle) else $error("shift clock moved outside a frame");
	a_release: assert property (p_release) else $error("data line not released");
	a_out_fall: assert property (p_out_fall) else $error("output changed while clock high");
	a_no_clash: assert property (p_no_clash) else $error("both ends drive the data line");
	a_drive_start: assert property (p_drive_start) else $error("read drive started wrongly");
	a_host_setup: assert property (p_host_setup) else $error("host data moved at clock rise");
	a_cmd_quiet: assert property (p_cmd_quiet) else $error("device drove after bad command");
	a_silent: assert property (p_silent) else $error("device drove during command");
endmodule // srtc_link_sva

// ==== verif/test_serial_rtc_with_scratch_ram.sv ====
module test_serial_rtc_with_scratch_ram;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk         = 1'b0;
	logic        rst         = 1'b1;
	logic        crystal_in  = 1'b0;
	logic        cyc         = 1'b0;
	logic        stb         = 1'b0;
	logic        we          = 1'b0;
	logic [7:0]  adr         = 8'h00;
	logic [31:0] wdat        = 32'h0;
	logic [3:0]  sel         = 4'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        xtal_o;
	logic [31:0] q;
	logic [7:0]  b;
	int          miscompares = 0;
	int          n_compared  = 0;
	// write command, data, read command, expected read
	logic [31:0] rows [10]   = '{32'hc0a5c1a5, 32'hee3cef3c, 32'hf055f100, 32'h90559100,
		32'h80858185, 32'h84b185b1, 32'h8eff8f80, 32'hc277c300, 32'h8e008f00, 32'h4011c1a5};
	// seconds kept off fifty-nine
	logic [7:0]  cal [8]     = '{8'h58, 8'h59, 8'h23, 8'h28, 8'h02, 8'h07, 8'h01, 8'h00};
	logic [7:0]  cal_exp [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h01, 8'h01, 8'h00};

	srtc_if link_if ();
	srtc_host i_srtc_host (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
		.wb_dat_o(rdat), .wb_ack_o(ack), .link(link_if.host));
	srtc_device #(.XTAL_DIV(4)) i_srtc_device (.clk(clk), .rst(rst), .crystal_in(crystal_in),
		.crystal_out(xtal_o), .link(link_if.device));
	srtc_link_sva i_srtc_link_sva (.clk(clk), .rst(rst), .ce(link_if.ce), .sclk(link_if.sclk),
		.host_io_o(link_if.host_io_o), .host_io_oe_n(link_if.host_io_oe_n),
		.dev_io_o(link_if.dev_io_o), .dev_io_oe_n(link_if.dev_io_oe_n), .io(link_if.io));

	always #25 clk = ~clk;
	// fast crystal keeps a second near 160 system clocks
	always @(posedge clk)
	begin
		repeat (19) @(posedge clk);
		crystal_in <= ~crystal_in;
	end

	task automatic conclude;
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic go(input logic [7:0] v);
		wb(1'b1, 8'h00, {16'h0, v, 8'h01});
		do wb(1'b0, 8'h04, 32'h0); while (q[0] !== 1'b0);
		b = q[15:8];
	endtask

	task automatic stop;
		wb(1'b1, 8'h00, 32'h2);
	endtask

	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		go(c);
		go(d);
		go(~d);
		stop;
	endtask

	task automatic rd(input logic [7:0] c, input logic [7:0] exp);
		go(c);
		go(8'h00);
		chk(b, exp);
		go(8'h00);
		chk(b, exp);
		stop;
	endtask

	task automatic do_reset;
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
	endtask

	initial
	begin
		do_reset;
		foreach (rows[i])
		begin
			wr(rows[i][31:24], rows[i][23:16]);
			rd(rows[i][15:8], rows[i][7:0]);
		end
		// still halted, so the oscillator output must rest low
		chk({7'h0, xtal_o}, 8'h00);
		// clock burst cut short must leave time untouched
		go(8'hbe);
		go(8'h80);
		go(8'h12);
		go(8'h05);
		stop;
		rd(8'h83, 8'h00);
		rd(8'h81, 8'h85);
		go(8'hfe);
		go(8'h11);
		go(8'h22);
		stop;
		rd(8'hc3, 8'h22);
		rd(8'hc1, 8'h11);
		go(8'hbe);
		foreach (cal[i])
			go(cal[i]);
		stop;
		repeat (600) @(posedge clk);
		go(8'hbf);
		go(8'h00);
		chk({4'h0, b[7:4]}, 8'h00);
		for (int i = 1; i < 8; i++)
		begin
			go(8'h00);
			chk(b, cal_exp[i]);
		end
		stop;
		do_reset;
		rd(8'h87, 8'h01);
		rd(8'hc1, 8'h00);
		wb(1'b0, 8'h08, 32'h0);
		chk(q[7:0] | q[15:8], 8'h00);
		wb(1'b0, 8'h04, 32'h0);
		chk({7'h0, q[1]}, 8'h00);
		conclude;
	end

	initial
	begin
		#3_000_000;
		miscompares++;
		conclude;
	end
endmodule // test_serial_rtc_with_scratch_ram
